// [asop_pipeline.sv]
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Take one new input sample on every rising clock edge; the code skips the six warm-up edges after each wake.
// - A sample's code appears exactly six clock cycles after its sampling edge; the code writes it to the buffer then, behind stalled words, or drops it if full
// - A fresh output word every clock, word rate equals clock rate.
// - Output words are twelve bits on a parallel data bus.
// - Differential offset binary: -FS zeros, zero midscale, +FS ones, half points quarters.
// - Single-ended: two references either side of common mode span full range.
// - Inputs beyond full scale saturate at minimum or maximum code, never wrap.
// - Power-down input high enters low power and stops conversion.
// - Format input high selects two's complement, low selects offset binary.
// - During power-down outputs are undefined and in-flight samples are lost.
module asop_pipeline
    import asop_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic signed [AIN_W-1:0] positive_analog_input,
    input wire logic signed [AIN_W-1:0] negative_analog_input,
    input wire logic signed [AIN_W-1:0] common_mode_level,
    input wire logic single_ended_select,
    input wire logic sleep_request_pin,
    input wire logic code_format_select,
    input wire logic capture_ready,
    output logic [CODE_W-1:0] sample_word,
    output logic sample_valid,
    output logic sample_overrun,
    output logic sleep_active
);
    localparam int LAST = PIPE_DEPTH - 1;

    asop_state_t st_ff;
    asop_state_t nxt_st;
    asop_word_t push_word;
    logic signed [DIFF_W-1:0] diff;
    logic take;
    logic push_ready;

    function automatic logic [CODE_W-1:0] asop_clip(input logic signed [DIFF_W-1:0] d);
        logic signed [DIFF_W-1:0] v;
        v = d + MID_OFS;
        if (v < ZERO_S) begin
            return CODE_MIN;
        end else if (v > MAX_S) begin
            return CODE_MAX;
        end
        return v[CODE_W-1:0];
    endfunction

    function automatic logic [CODE_W-1:0] asop_format(input logic [CODE_W-1:0] c,
                                                      input logic tc);
        return tc ? {~c[CODE_W-1], c[CODE_W-2:0]} : c;
    endfunction

    // Conversion only runs once awake and the warm-up count has run out
    assign take = !st_ff.asleep && (st_ff.warm == WARMUP_CYCLES);

    always_comb begin
        // Full scale is two references of difference in either mode, so both are halved
        if (st_ff.single) begin
            diff = (DIFF_W'(positive_analog_input) - DIFF_W'(common_mode_level)) >>> 1;
        end else begin
            diff = (DIFF_W'(positive_analog_input)
                    - DIFF_W'(negative_analog_input)) >>> 1;
        end
    end

    always_comb begin
        push_word.vld = st_ff.vld[LAST];
        push_word.code = asop_format(st_ff.code[LAST], st_ff.fmt_tc);
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.sleep_sync = {st_ff.sleep_sync[1:0], sleep_request_pin};
        nxt_st.fmt_sync = {st_ff.fmt_sync[1:0], code_format_select};
        nxt_st.se_sync = {st_ff.se_sync[1:0], single_ended_select};
        if (st_ff.sleep_sync[1] == st_ff.sleep_sync[2]) begin
            nxt_st.asleep = st_ff.sleep_sync[2];
        end
        // Format flips mid-stream; words around the change are not guarded
        if (st_ff.fmt_sync[1] == st_ff.fmt_sync[2]) begin
            nxt_st.fmt_tc = st_ff.fmt_sync[2];
        end
        if (st_ff.se_sync[1] == st_ff.se_sync[2]) begin
            nxt_st.single = st_ff.se_sync[2];
        end
        if (st_ff.asleep) begin
            nxt_st.warm = '0;
        end else if (st_ff.warm != WARMUP_CYCLES) begin
            nxt_st.warm = 4'(st_ff.warm + 1'b1);
        end
        // One sample per edge, clipped then shifted down the pipe
        nxt_st.vld = {st_ff.vld[LAST-1:0], take};
        nxt_st.code = {st_ff.code[LAST-1:0], asop_clip(diff)};
        if (st_ff.asleep) begin
            nxt_st.vld = '0;
        end
        // The converter cannot stall, so a full buffer drops the word
        nxt_st.overrun = push_word.vld && !push_ready;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_ff <= ST_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Sixth edge after sampling writes the buffer, whose head is visible at once
    asop_fifo #(
        .W(CODE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .flush(st_ff.asleep),
        .in_valid(push_word.vld),
        .in_data(push_word.code),
        .in_ready(push_ready),
        .out_valid(sample_valid),
        .out_data(sample_word),
        .out_ready(capture_ready)
    );

    assign sample_overrun = st_ff.overrun;
    assign sleep_active = st_ff.asleep;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sample_each_edge_a: assert property (
        take |=> st_ff.vld[0] && st_ff.code[0] == asop_clip($past(diff)))
        else $error("sample not captured on edge");

    latency_six_a: assert property (
        take ##1 (!st_ff.asleep [*6]) |-> push_word.vld && st_ff.code[LAST] == $past(st_ff.code[0], 5))
        else $error("sample code not pushed six cycles later");

    word_rate_a: assert property (
        (take [*2]) ##1 (!st_ff.asleep [*6]) |-> push_word.vld && $past(push_word.vld))
        else $error("output word missing in a cycle");

    diff_midscale_a: assert property (
        take && !st_ff.single && positive_analog_input == negative_analog_input
        |=> st_ff.code[0] == CODE_MID)
        else $error("zero differential input not midscale");

    single_quarter_a: assert property (
        take && st_ff.single
        && DIFF_W'(positive_analog_input) == DIFF_W'(common_mode_level) - VREF_UNITS
        |=> st_ff.code[0] == CODE_QTR)
        else $error("single-ended minus one reference not quarter code");

    overrange_clip_a: assert property (
        take && !st_ff.single && diff > MAX_S |=> st_ff.code[0] == CODE_MAX)
        else $error("overrange input not clipped to maximum");

    sleep_stops_a: assert property (
        st_ff.asleep |=> !st_ff.vld[0] ##1 !push_word.vld)
        else $error("conversion continued in power-down");

    twos_comp_a: assert property (
        push_word.vld && st_ff.fmt_tc |-> push_word.code[CODE_W-1] != st_ff.code[LAST][CODE_W-1])
        else $error("two's complement sign bit not inverted");

    sleep_flush_a: assert property (
        st_ff.asleep |=> st_ff.vld == '0 && !sample_valid)
        else $error("pipeline not flushed in power-down");

    wake_quiet_a: assert property (
        $fell(st_ff.asleep) |-> !push_word.vld [*8])
        else $error("valid word too soon after wake");

    wake_first_word_c: cover property ($fell(st_ff.asleep) ##[1:20] sample_valid);
    overrun_seen_c: cover property (st_ff.overrun);
    twos_comp_push_c: cover property (push_word.vld && st_ff.fmt_tc && capture_ready);

endmodule

`default_nettype wire

// [asop_pkg.sv]
package asop_pkg;

    localparam int CODE_W = 12;
    localparam int AIN_W = 16;
    localparam int DIFF_W = 18;
    localparam int PIPE_DEPTH = 6;
    localparam int FIFO_DEPTH = 4;
    localparam int SYNC_STAGES = 3;

    localparam logic [CODE_W-1:0] CODE_MIN = 12'h000;
    localparam logic [CODE_W-1:0] CODE_QTR = 12'h400;
    localparam logic [CODE_W-1:0] CODE_MID = 12'h800;
    localparam logic [CODE_W-1:0] CODE_3QTR = 12'hc00;
    localparam logic [CODE_W-1:0] CODE_MAX = 12'hfff;

    // One reference of input swing, in input units, spans a quarter of the code range
    localparam logic signed [DIFF_W-1:0] VREF_UNITS = 18'sh00800;
    localparam logic signed [DIFF_W-1:0] MID_OFS = 18'sh00800;
    localparam logic signed [DIFF_W-1:0] MAX_S = 18'sh00fff;
    localparam logic signed [DIFF_W-1:0] ZERO_S = 18'sh00000;

    localparam logic [3:0] WARMUP_CYCLES = 4'h6;

    typedef struct packed {
        logic vld;
        logic [CODE_W-1:0] code;
    } asop_word_t;

    typedef struct packed {
        logic [SYNC_STAGES-1:0] sleep_sync;
        logic [SYNC_STAGES-1:0] fmt_sync;
        logic [SYNC_STAGES-1:0] se_sync;
        logic asleep;
        logic fmt_tc;
        logic single;
        logic [3:0] warm;
        logic [PIPE_DEPTH-1:0] vld;
        logic [PIPE_DEPTH-1:0][CODE_W-1:0] code;
        logic overrun;
    } asop_state_t;

    localparam asop_state_t ST_RESET = '{
        sleep_sync: 3'h7,
        fmt_sync: 3'h0,
        se_sync: 3'h0,
        asleep: 1'b1,
        fmt_tc: 1'b0,
        single: 1'b0,
        warm: 4'h0,
        vld: 6'h00,
        code: 72'h0,
        overrun: 1'b0
    };

endpackage

// [asop_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

module asop_fifo #(
    parameter int W = 12,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [PW:0] cnt;
    } asop_fifo_state_t;

    asop_fifo_state_t st_ff;
    asop_fifo_state_t nxt_st;
    logic wr_en;
    logic rd_en;

    function automatic logic [PW-1:0] asop_ptr_inc(input logic [PW-1:0] p);
        return (p == LAST) ? '0 : PW'(p + 1'b1);
    endfunction

    assign in_ready = (st_ff.cnt != FULL);
    assign out_valid = (st_ff.cnt != '0);
    assign out_data = st_ff.mem[st_ff.rd];
    assign wr_en = in_valid && in_ready;
    assign rd_en = out_valid && out_ready;

    always_comb begin
        nxt_st = st_ff;
        if (flush) begin
            nxt_st.wr = '0;
            nxt_st.rd = '0;
            nxt_st.cnt = '0;
        end else begin
            if (wr_en) begin
                nxt_st.mem[st_ff.wr] = in_data;
                nxt_st.wr = asop_ptr_inc(st_ff.wr);
            end
            if (rd_en) begin
                nxt_st.rd = asop_ptr_inc(st_ff.rd);
            end
            if (wr_en && !rd_en) begin
                nxt_st.cnt = (PW+1)'(st_ff.cnt + 1'b1);
            end else if (rd_en && !wr_en) begin
                nxt_st.cnt = (PW+1)'(st_ff.cnt - 1'b1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule

`default_nettype wire

// [asop_capture_model.sv]
`timescale 1ns/1ps
`default_nettype none

module asop_capture_model
    import asop_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic stall,
    input wire logic [CODE_W-1:0] sample_word,
    input wire logic sample_valid,
    output logic capture_ready,
    output logic [CODE_W-1:0] last_word
);
    // Ready is withdrawn only when the bench orders a stall
    assign capture_ready = !stall;
    // Latch on the conversion clock's rising edge
    // Words near a format change are not judged, the bench waits them out
    always_ff @(posedge clk) begin
        if (!resetn) begin
            last_word <= '0;
        end else if (sample_valid && capture_ready) begin
            last_word <= sample_word;
        end
    end
endmodule

`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tb;
    import asop_pkg::*;
    typedef struct packed {
        logic se;
        logic fmt;
        logic [15:0] p;
        logic [15:0] n;
        logic [15:0] cm;
        logic [CODE_W-1:0] exp;
    } asop_row_t;
    logic clk, resetn, se, slp, fmt, stall, rdy, vld, ovr, asl, flag;
    logic signed [AIN_W-1:0] p, n, cm;
    logic [CODE_W-1:0] word, last;
    int n_mismatch, total_checks, i;
    asop_row_t rows [15];

    asop_pipeline i_asop_pipeline (.clk(clk), .resetn(resetn), .positive_analog_input(p),
        .negative_analog_input(n), .common_mode_level(cm), .single_ended_select(se),
        .sleep_request_pin(slp), .code_format_select(fmt), .capture_ready(rdy),
        .sample_word(word), .sample_valid(vld), .sample_overrun(ovr), .sleep_active(asl));
    asop_capture_model i_asop_capture_model (.clk(clk), .resetn(resetn), .stall(stall),
        .sample_word(word), .sample_valid(vld), .capture_ready(rdy), .last_word(last));

    task automatic check(input string what, input logic [CODE_W-1:0] seen,
        input logic [CODE_W-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end

    // Whole run is near 400 cycles, so 3000 leaves room
    initial begin
        #(40 * 3000);
        n_mismatch++;
        test_done();
    end

    initial begin
        {resetn, se, slp, fmt, stall, p, n, cm} = '0;
        rows = '{'{1'b0, 1'b0, 16'hf800, 16'h0800, 16'h0000, 12'h000},
            '{1'b0, 1'b0, 16'hfc00, 16'h0400, 16'h0000, 12'h400},
            '{1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0000, 12'h800},
            '{1'b0, 1'b0, 16'h0400, 16'hfc00, 16'h0000, 12'hc00},
            '{1'b0, 1'b0, 16'h0800, 16'hf800, 16'h0000, 12'hfff},
            '{1'b0, 1'b0, 16'h4e20, 16'hb1e0, 16'h0000, 12'hfff},
            '{1'b0, 1'b0, 16'hb1e0, 16'h4e20, 16'h0000, 12'h000},
            '{1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0000, 12'h000},
            '{1'b0, 1'b1, 16'h0800, 16'hf800, 16'h0000, 12'h7ff},
            '{1'b0, 1'b1, 16'hf800, 16'h0800, 16'h0000, 12'h800},
            '{1'b1, 1'b0, 16'hf3e8, 16'h03e8, 16'h03e8, 12'h000},
            '{1'b1, 1'b0, 16'hfbe8, 16'h03e8, 16'h03e8, 12'h400},
            '{1'b1, 1'b0, 16'h03e8, 16'h03e8, 16'h03e8, 12'h800},
            '{1'b1, 1'b0, 16'h0be8, 16'h03e8, 16'h03e8, 12'hc00},
            '{1'b1, 1'b0, 16'h13e8, 16'h03e8, 16'h03e8, 12'hfff}};
        repeat (7) @(negedge clk);
        check("reset sleep", CODE_W'(asl), 12'h001);
        check("reset valid", CODE_W'(vld), 12'h000);
        resetn = 1;
        for (i = 0; i < 40 && vld !== 1'b1; i++) @(negedge clk);
        // Long settling hides sync delay and format-change words
        foreach (rows[r]) begin
            {se, fmt, p, n, cm} = {rows[r].se, rows[r].fmt, rows[r].p, rows[r].n, rows[r].cm};
            repeat (20) @(negedge clk);
            check("code", last, rows[r].exp);
        end
        {se, fmt, p, n, cm} = '0;
        repeat (20) @(negedge clk);
        p = 16'h0400;
        n = 16'hfc00;
        repeat (6) @(negedge clk);
        check("before latency", word, 12'h800);
        @(negedge clk);
        check("at latency", word, 12'hc00);
        for (i = 0; i < 8; i++) begin
            check("every cycle", CODE_W'(vld), 12'h001);
            @(negedge clk);
        end
        stall = 1;
        flag = 0;
        for (i = 0; i < 12; i++) begin
            @(negedge clk);
            flag |= ovr;
        end
        check("overrun", CODE_W'(flag), 12'h001);
        check("full valid", CODE_W'(vld), 12'h001);
        stall = 0;
        slp = 1;
        for (i = 0; i < 10 && asl !== 1'b1; i++) @(negedge clk);
        repeat (2) @(negedge clk);
        check("sleep", CODE_W'(asl), 12'h001);
        check("flushed", CODE_W'(vld), 12'h000);
        slp = 0;
        for (i = 0; i < 10 && asl !== 1'b0; i++) @(negedge clk);
        check("awake", CODE_W'(asl), 12'h000);
        flag = 0;
        for (i = 0; i < 12; i++) begin
            flag |= vld;
            @(negedge clk);
        end
        check("warm up", CODE_W'(flag), 12'h000);
        for (i = 0; i < 10 && vld !== 1'b1; i++) @(negedge clk);
        check("resumed", CODE_W'(vld), 12'h001);
        // Reset in mid-stream must drop the words in flight and fall back to sleep
        resetn = 0;
        repeat (2) @(negedge clk);
        check("mid reset sleep", CODE_W'(asl), 12'h001);
        check("mid reset valid", CODE_W'(vld), 12'h000);
        resetn = 1;
        @(negedge clk);
        check("mid reset hold", CODE_W'(asl), 12'h001);
        test_done();
    end
endmodule

`default_nettype wire
